//--- src/eub_uart.v
// Purpose: Enhanced UART with FIFOs, 16-bit baud divisor, break/sync and interrupts behind APB
// Assumes: 8N1 framing; tx_done and break_done flags are set-wins over clear
// Assumes: a break request is honoured only while the transmitter is idle
// Notes: One transmit engine serves break, sync and FIFO bytes
// How it works
// R1: Set tx done flag when TX FIFO drains
// R2: Writing 0 clears tx flag and enable
// R3: Tx done enable lets flag raise interrupt
// R4: Data read pops oldest receive byte
// R5: Data write pushes byte into transmit FIFO
// R6: Divisor is two byte registers reset zero
// R7: Bit time is divisor plus one clocks
// R8: Break enable raises interrupt after break done
// R9: Sample point code picks 50/62.5/69/75 percent
// R10: Break flag set by hardware, software clears
// R11: Sync byte follows break when selected
// R12: Break length 13 to 16 bit times
// R13: Break bit holds line low, self clears
// R14: FIFO bytes wait until sync is sent
// R15: Interrupt needs global enable and enabled flag
// R16: Receive sampling counted from start edge

`include "eub_consts.vh"
module eub_uart #(
  parameter DEPTH = 15, // FIFO entries each way
  parameter AW = 4 // FIFO index width
) (
  input wire core_clk, // System clock
  input wire rst, // Asynchronous reset, high
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error for unmapped address
  input wire rx_pin, // Serial receive line
  output reg tx_pin, // Serial transmit line
  output reg irq // Level interrupt
);

  // Transmit engine states
  // S_BREAK holds the line low; S_BYTE shifts a start-data-stop frame
  localparam S_IDLE = 2'h0;
  localparam S_BREAK = 2'h1;
  localparam S_BYTE = 2'h2;

  // Registers
  reg [15:0] div_reg;
  reg [7:0] brk_cfg_reg; // enable, sample, sync, length; flag kept separately
  reg brk_flag_reg;
  reg brk_busy_reg;
  reg tx_flag_reg;
  reg tx_en_reg;
  reg gie_reg;

  // FIFOs
  reg [7:0] txm [0:DEPTH-1];
  reg [7:0] rxm [0:DEPTH-1];
  reg [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  // Byte counts run one bit wider than the pointers to tell full from empty
  reg [AW:0] tx_cnt_reg, rx_cnt_reg;

  // Transmitter
  reg [1:0] tx_st_reg;
  reg [15:0] tx_div_reg;
  reg [4:0] tx_bit_reg;
  // Holds stop, data and start; shifts right one bit per tick
  reg [9:0] tx_sh_reg;
  reg tx_sync_pend_reg;

  // Receiver
  // rx_prev_reg trails the second stage to find the falling start edge
  reg rx_s1_reg, rx_s2_reg, rx_prev_reg;
  reg rx_act_reg;
  reg [15:0] rx_div_reg;
  reg [3:0] rx_bit_reg;
  reg [7:0] rx_sh_reg;
  wire [15:0] samp_cnt;
  wire tx_done_evt;

  // APB decode
  wire acc = psel && penable;
  wire [9:0] idx = paddr[11:2];
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = (idx == {2'h0, `EUB_IDX_CTRL});
  wire hit_irq = (idx == {2'h0, `EUB_IDX_IRQ});
  wire hit_data = (idx == {2'h0, `EUB_IDX_DATA});
  wire hit_divl = (idx == {2'h0, `EUB_IDX_DIVL});
  wire hit_divh = (idx == {2'h0, `EUB_IDX_DIVH});
  wire hit_brk = (idx == {2'h0, `EUB_IDX_BRK});
  wire mapped = hit_ctrl | hit_irq | hit_data | hit_divl | hit_divh | hit_brk;
  // FIFO strobes are refused when full or empty
  wire tx_push = wr && hit_data && (tx_cnt_reg != DEPTH[AW:0]); // R5
  wire rx_pop = rd && hit_data && (rx_cnt_reg != {(AW+1){1'b0}}); // R4
  wire tx_pop;
  wire rx_push;
  // Break request takes effect on the completing edge, like any write
  wire brk_start = wr && pready && hit_ctrl && pwdata[`EUB_CTRL_BREAK] && !brk_busy_reg;
  wire brk_done;
  wire [4:0] brk_bits = `EUB_BRK_BASE + {3'h0, brk_cfg_reg[`EUB_BRK_LENH:`EUB_BRK_LENL]}; // R12

  // Sample point helper
  // The count runs from the detected start edge, not from the line edge
  eub_sample_point u_sp (
    .divisor(div_reg),
    .point_sel(brk_cfg_reg[`EUB_BRK_SPH:`EUB_BRK_SPL]), // R9
    .sample_cnt(samp_cnt)
  );

  // Bus answer registers; answer one cycle into the access phase
  // The pready term keeps a held request from being answered twice
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= 32'h0000_0000;
      // Read data is chosen once, at the first access edge
      if (psel && penable && !pready && !pwrite) begin
        if (hit_ctrl) prdata <= {28'h000_0000, brk_busy_reg, 3'h0}; // R13
        if (hit_irq) prdata <= {24'h00_0000, gie_reg, 6'h00, tx_flag_reg};
        if (hit_data) prdata <= {24'h00_0000, rxm[rx_rp_reg]}; // R4
        if (hit_divl) prdata <= {24'h00_0000, div_reg[7:0]};
        if (hit_divh) prdata <= {24'h00_0000, div_reg[15:8]};
        if (hit_brk) prdata <= {24'h00_0000, brk_cfg_reg[7:4], brk_flag_reg, brk_cfg_reg[2:0]};
      end
    end
  end

  // Writes take effect on the completing edge only
  wire wr_done = wr && pready;

  // Configuration and divisor registers
  // Divisor bytes are independent; a new rate applies from the next bit
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg <= `EUB_RST_DIV; // R6
      brk_cfg_reg <= `EUB_RST_BYTE;
      gie_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else if (wr_done) begin
      if (hit_divl) div_reg[7:0] <= pwdata[7:0]; // R6
      if (hit_divh) div_reg[15:8] <= pwdata[7:0]; // R6
      if (hit_brk) brk_cfg_reg <= pwdata[7:0];
      if (hit_irq) begin
        gie_reg <= pwdata[`EUB_IRQ_GIE];
        tx_en_reg <= pwdata[`EUB_IRQ_TI]; // R2 R3
      end
    end
  end

  // Sticky flags; a hardware set in the clearing cycle wins
  // Clearing is by writing zero, so writing ones back leaves a flag alone
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_flag_reg <= 1'b0;
      brk_flag_reg <= 1'b0;
    end else begin
      if (tx_done_evt) tx_flag_reg <= 1'b1; // R1
      else if (wr_done && hit_irq && !pwdata[`EUB_IRQ_TI]) tx_flag_reg <= 1'b0; // R2
      if (brk_done) brk_flag_reg <= 1'b1; // R10
      else if (wr_done && hit_brk && !pwdata[`EUB_BRK_FLAG]) brk_flag_reg <= 1'b0; // R10
    end
  end

  // Interrupt output, registered
  // Registering costs a cycle of latency but keeps the pin glitch free
  always @(posedge core_clk or posedge rst) begin
    if (rst) irq <= 1'b0;
    else irq <= gie_reg && ((tx_flag_reg && tx_en_reg) || (brk_flag_reg && brk_cfg_reg[`EUB_BRK_IEN])); // R3 R8 R15
  end

  // FIFO storage, one generated always block per entry
  // Storage has no reset; the pointers decide which entries are valid
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_fifo
      always @(posedge core_clk) begin
        if (tx_push && wr_done && tx_wp_reg == g[AW-1:0]) txm[g] <= pwdata[7:0];
        if (rx_push && rx_wp_reg == g[AW-1:0]) rxm[g] <= rx_sh_reg;
      end
    end
  endgenerate

  // Pointer step with wrap after the last entry
  function [AW-1:0] nxt;
    input [AW-1:0] p;
    begin
      nxt = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // FIFO pointers; a full receive FIFO drops the new byte
  // Reading an empty receive FIFO returns a stale entry and pops nothing
  wire rx_full = (rx_cnt_reg == DEPTH[AW:0]);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_wp_reg <= {AW{1'b0}};
      tx_rp_reg <= {AW{1'b0}};
      rx_wp_reg <= {AW{1'b0}};
      rx_rp_reg <= {AW{1'b0}};
      tx_cnt_reg <= {(AW+1){1'b0}};
      rx_cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (tx_push && wr_done) tx_wp_reg <= nxt(tx_wp_reg);
      if (tx_pop) tx_rp_reg <= nxt(tx_rp_reg);
      tx_cnt_reg <= tx_cnt_reg + {{AW{1'b0}}, tx_push && wr_done} - {{AW{1'b0}}, tx_pop};
      if (rx_push && !rx_full) rx_wp_reg <= nxt(rx_wp_reg);
      if (rx_pop && pready) rx_rp_reg <= nxt(rx_rp_reg); // R4
      rx_cnt_reg <= rx_cnt_reg + {{AW{1'b0}}, rx_push && !rx_full} - {{AW{1'b0}}, rx_pop && pready};
    end
  end

  // Transmit engine: break field, optional sync, then FIFO bytes
  // The sync start bit follows the break at once, so the line stays low through it
  wire tx_tick = (tx_div_reg == 16'h0000); // R7
  wire tx_can_load = (tx_st_reg == S_IDLE) && !brk_busy_reg && (tx_cnt_reg != {(AW+1){1'b0}}); // R14
  // A byte is popped only when the engine really loads it, never beside a break start
  assign tx_pop = tx_can_load && !brk_start;
  // Last bit of a break or a frame ends on this tick
  wire last_bit = (tx_st_reg != S_IDLE) && tx_tick && (tx_bit_reg == 5'h01);
  wire byte_end = last_bit && (tx_st_reg == S_BYTE);
  // Break completion waits for the sync frame when one is sent
  assign brk_done = brk_busy_reg && last_bit &&
    ((tx_st_reg == S_BREAK && !tx_sync_pend_reg) || (tx_st_reg == S_BYTE)); // R8 R10 R11
  // Completion counts only for data bytes that leave an empty FIFO
  assign tx_done_evt = byte_end && !brk_busy_reg && (tx_cnt_reg == {(AW+1){1'b0}}); // R1

  // Shift engine; every bit lasts divisor plus one clocks
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_reg <= S_IDLE;
      tx_div_reg <= 16'h0000;
      tx_bit_reg <= 5'h00;
      tx_sh_reg <= 10'h3ff;
      tx_sync_pend_reg <= 1'b0;
      brk_busy_reg <= 1'b0;
      tx_pin <= 1'b1;
    end else begin
      case (tx_st_reg)
        S_IDLE: begin
          tx_pin <= 1'b1;
          // A break request outranks queued data
          if (brk_start) begin
            brk_busy_reg <= 1'b1; // R13
            tx_sync_pend_reg <= brk_cfg_reg[`EUB_BRK_SYNC]; // R11
            tx_st_reg <= S_BREAK;
            tx_bit_reg <= brk_bits; // R12
            tx_div_reg <= div_reg;
            tx_pin <= 1'b0; // R13
          end else if (tx_can_load) begin
            tx_sh_reg <= {1'b1, txm[tx_rp_reg], 1'b0}; // R5
            tx_st_reg <= S_BYTE;
            tx_bit_reg <= {1'b0, `EUB_FRAME_BITS};
            tx_div_reg <= div_reg;
            tx_pin <= 1'b0;
          end
        end

        // Line held low while the break bit times count down
        S_BREAK: begin
          tx_div_reg <= tx_tick ? div_reg : tx_div_reg - 16'h0001; // R7
          if (tx_tick) begin
            tx_bit_reg <= tx_bit_reg - 5'h01;
            if (tx_bit_reg == 5'h01) begin
              if (tx_sync_pend_reg) begin
                tx_sh_reg <= {1'b1, `EUB_SYNC_BYTE, 1'b0}; // R11
                tx_st_reg <= S_BYTE;
                tx_bit_reg <= {1'b0, `EUB_FRAME_BITS};
                tx_pin <= 1'b0;
              end else begin
                brk_busy_reg <= 1'b0; // R13
                tx_st_reg <= S_IDLE;
                tx_pin <= 1'b1;
              end
            end
          end
        end

        // Start, eight data bits LSB first, then the stop bit
        S_BYTE: begin
          tx_div_reg <= tx_tick ? div_reg : tx_div_reg - 16'h0001;
          if (tx_tick) begin
            tx_bit_reg <= tx_bit_reg - 5'h01;
            tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
            tx_pin <= tx_sh_reg[1];
            if (tx_bit_reg == 5'h01) begin
              tx_st_reg <= S_IDLE;
              tx_pin <= 1'b1;
              if (brk_busy_reg) begin
                brk_busy_reg <= 1'b0; // R13 R14
                tx_sync_pend_reg <= 1'b0;
              end
            end
          end
        end
        default: tx_st_reg <= S_IDLE;
      endcase
    end
  end

  // Receive line synchroniser, edge detect after second stage
  // Idle-high reset values keep a false start edge from following reset
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  // Receiver: first sample at chosen point after the start edge, then every bit period
  // The start edge is seen three clocks late, which shifts every sample alike
  wire rx_tick = rx_act_reg && (rx_div_reg == 16'h0000);
  // Push needs a high stop bit and room; a full FIFO or a framing error drops the byte
  assign rx_push = rx_tick && (rx_bit_reg == `EUB_FRAME_BITS - 4'h1) && rx_s2_reg && !rx_full;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_act_reg <= 1'b0;
      rx_div_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
    end else if (!rx_act_reg) begin
      if (rx_prev_reg && !rx_s2_reg) begin
        rx_act_reg <= 1'b1;
        rx_div_reg <= samp_cnt; // R16
        rx_bit_reg <= 4'h0;
      end
    end else begin
      rx_div_reg <= rx_tick ? div_reg : rx_div_reg - 16'h0001;
      if (rx_tick) begin
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rx_s2_reg) rx_act_reg <= 1'b0; // False start rejected
        if (rx_bit_reg != 4'h0) rx_sh_reg <= {rx_s2_reg, rx_sh_reg[7:1]};
        if (rx_bit_reg == `EUB_FRAME_BITS - 4'h1) rx_act_reg <= 1'b0;
      end
    end
  end

endmodule // eub_uart

//--- inc/eub_consts.vh
// Purpose: Register map, field positions and timing constants of the enhanced UART block
// Assumes: APB byte addresses are four times the printed register index
// Notes: Included by the UART top and its bit-timing helper
`ifndef EUB_CONSTS_VH
`define EUB_CONSTS_VH
// Register indices
`define EUB_IDX_CTRL 8'h00_b1
`define EUB_IDX_IRQ 8'h00_b4
`define EUB_IDX_DATA 8'h00_b5
`define EUB_IDX_DIVL 8'h00_b6
`define EUB_IDX_DIVH 8'h00_b7
`define EUB_IDX_BRK 8'h00_c1
// Register reset values
`define EUB_RST_BYTE 8'h00
`define EUB_RST_DIV 16'h0000
// Interrupt register fields
`define EUB_IRQ_GIE 7
`define EUB_IRQ_TI 0
// Control register fields
`define EUB_CTRL_BREAK 3
// Break configuration register fields
`define EUB_BRK_IEN 7
`define EUB_BRK_SPH 5
`define EUB_BRK_SPL 4
`define EUB_BRK_FLAG 3
`define EUB_BRK_SYNC 2
`define EUB_BRK_LENH 1
`define EUB_BRK_LENL 0
// Break length base in bit times for code 00
`define EUB_BRK_BASE 5'h0_d
// Sync byte value of a break header
`define EUB_SYNC_BYTE 8'h0_55
// Sample point numerators over sixteen
`define EUB_SP_50 5'h0_8
`define EUB_SP_62 5'h0_a
`define EUB_SP_69 5'h0_b
`define EUB_SP_75 5'h0_c
// Bits in a frame with start and stop
`define EUB_FRAME_BITS 4'h0_a
`endif

//--- src/eub_sample_point.v
// Purpose: Converts the divisor and sample-point code into a count inside the bit
// Assumes: Divisor gives cycles per bit minus one
// Notes: Purely combinational, shared by the receiver
`include "eub_consts.vh"
module eub_sample_point (
  input wire [15:0] divisor, // Baud divisor
  input wire [1:0] point_sel, // Sample point code
  output reg [15:0] sample_cnt // Cycle count from start edge
);
  reg [4:0] num;
  reg [20:0] prod;
  // Fraction of the bit period, rounded down; a zero divisor samples at cycle 0
  always @* begin
    case (point_sel)
      2'h0: num = `EUB_SP_50;
      2'h1: num = `EUB_SP_62;
      2'h2: num = `EUB_SP_69;
      default: num = `EUB_SP_75;
    endcase
    prod = ({5'h0_0, divisor} + 21'h0_0001) * {16'h0_000, num};
    sample_cnt = prod[19:4];
  end
endmodule // eub_sample_point

//--- sim/eub_uart_props.sv
// Purpose: Port checks of the enhanced UART
// Assumes: Byte address is four times the index
// Notes: Shadows follow what software wrote
`include "eub_consts.vh"
module eub_uart_props (
  input wire core_clk, // Clock
  input wire rst, // Reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Direction
  input wire [11:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire rx_pin, // Serial in
  input wire tx_pin, // Serial out
  input wire irq // Interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] A_CTRL = `EUB_IDX_CTRL * 4;
  localparam logic [11:0] A_IRQ = `EUB_IDX_IRQ * 4;
  localparam logic [11:0] A_DATA = `EUB_IDX_DATA * 4;
  localparam logic [11:0] A_DIVL = `EUB_IDX_DIVL * 4;
  localparam logic [11:0] A_DIVH = `EUB_IDX_DIVH * 4;
  localparam logic [11:0] A_BRK = `EUB_IDX_BRK * 4;
  logic [15:0] div_q;
  logic gie_q;
  logic ten_q;
  logic [7:0] cfg_q;
  logic [23:0] lo_cnt;
  wire wr = psel && penable && pwrite && pready && !pslverr;
  wire rd = pready && !pwrite;
  // Shadows update only at the completing edge, like the slave
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
      gie_q <= 1'b0;
      ten_q <= 1'b0;
      cfg_q <= 8'h00;
      lo_cnt <= 24'h00_0000;
    end else begin
      lo_cnt <= tx_pin ? 24'h00_0000 : lo_cnt + 24'h00_0001;
      if (wr && paddr == A_DIVL) div_q[7:0] <= pwdata[7:0];
      if (wr && paddr == A_DIVH) div_q[15:8] <= pwdata[7:0];
      if (wr && paddr == A_IRQ) gie_q <= pwdata[7];
      if (wr && paddr == A_IRQ) ten_q <= pwdata[0];
      if (wr && paddr == A_BRK) cfg_q <= pwdata[7:0] & 8'hb7;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Irq is registered, so the shadows must be settled two edges
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_div; rd && (paddr == A_DIVL || paddr == A_DIVH) |->
    prdata == {24'h00_0000, paddr == A_DIVH ? div_q[15:8] : div_q[7:0]}; endproperty
  a_div: assert property (p_div) else $error("divisor readback");
  property p_gie; !gie_q && !$past(gie_q) |-> !irq; endproperty
  a_gie: assert property (p_gie) else $error("irq without global enable");
  property p_src; !ten_q && !cfg_q[7] && !$past(ten_q) && !$past(cfg_q[7]) |-> !irq; endproperty
  a_src: assert property (p_src) else $error("irq without source enable");
  property p_cfg; rd && paddr == A_BRK |-> (prdata[7:0] & 8'hb7) == cfg_q; endproperty
  a_cfg: assert property (p_cfg) else $error("break config readback");
  // Longest low run: sixteen break bit times plus the sync start bit
  property p_low; lo_cnt <= ({8'h00, div_q} + 24'h00_0001) * 24'h00_0011; endproperty
  a_low: assert property (p_low) else $error("line low too long");
  property p_ctrl; rd && paddr == A_CTRL |-> (prdata & 32'hffff_fff7) == 32'h0000_0000; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  property p_data; rd && paddr == A_DATA |-> prdata[31:8] == 24'h00_0000; endproperty
  a_data: assert property (p_data) else $error("data upper bits");
endmodule // eub_uart_props
bind eub_uart eub_uart_props u_props (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .rx_pin, .tx_pin, .irq);

//--- sim/eub_remote_node.sv
// Purpose: Far-side serial node, sends and receives 8N1 frames
// Assumes: BT clocks per bit; line idles high
// Notes: A get_byte timeout leaves an unknown byte for the bench to catch; a low_run timeout leaves a wrong count
module eub_remote_node #(
  parameter int BT = 8 // Clocks per bit
) (
  input wire core_clk, // Clock
  input wire tx_pin, // From the UART
  output logic rx_pin // Into the UART
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rx_pin = 1'b1;
  // Start bit, LSB first, one stop bit
  task automatic send(input logic [7:0] b);
    rx_pin <= 1'b0;
    repeat (BT) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rx_pin <= b[i];
      repeat (BT) @(posedge core_clk);
    end
    rx_pin <= 1'b1;
    repeat (BT) @(posedge core_clk);
  endtask
  // Counts sampled low cycles of one low stretch
  task automatic low_run(output int n);
    int k;
    n = 0;
    k = 0;
    while (tx_pin !== 1'b0 && k < 3000) begin @(posedge core_clk); k++; end
    while (tx_pin === 1'b0 && n < 3000) begin @(posedge core_clk); n++; end
  endtask
  // Finishes a frame whose start bit low_run has already counted
  task automatic get_rest(output logic [7:0] b);
    repeat (BT / 2 - 1) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = tx_pin;
      repeat (BT) @(posedge core_clk);
    end
  endtask
  // Samples mid-bit, returns in the stop bit so a zero bit 7 is not a start
  task automatic get_byte(output logic [7:0] b);
    int k;
    k = 0;
    b = 'x;
    while (tx_pin !== 1'b0 && k < 3000) begin @(posedge core_clk); k++; end
    if (k < 3000) begin
      repeat (BT + BT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        b[i] = tx_pin;
        repeat (BT) @(posedge core_clk);
      end
    end
  endtask
endmodule // eub_remote_node

//--- sim/eub_uart_tb.sv
// Purpose: Self-checking bench of the enhanced UART
// Assumes: Divisor 7 gives eight clocks a bit
// Notes: Break rows in a table, the rest by hand
`include "eub_consts.vh"
module eub_uart_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] A_CTRL = `EUB_IDX_CTRL * 4;
  localparam logic [11:0] A_IRQ = `EUB_IDX_IRQ * 4;
  localparam logic [11:0] A_DATA = `EUB_IDX_DATA * 4;
  localparam logic [11:0] A_DIVL = `EUB_IDX_DIVL * 4;
  localparam logic [11:0] A_DIVH = `EUB_IDX_DIVH * 4;
  localparam logic [11:0] A_BRK = `EUB_IDX_BRK * 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, rx_pin, tx_pin, irq;
  int miscompares = 0;
  int compares = 0;
  int n;
  logic [31:0] q;
  logic e;
  logic [7:0] b;
  logic [1:0] r_len [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic r_sync [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // With sync, the sync frame's start bit lengthens the low run by one bit time
  int r_low [4] = '{112, 112, 128, 128};
  always #4 core_clk = ~core_clk;
  eub_uart DUT (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_pin, .tx_pin, .irq);
  eub_remote_node #(.BT(8)) RN (.core_clk, .tx_pin, .rx_pin);
  task automatic end_sim();
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask
  // One transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin chk("pready", 1, 0); end_sim(); end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(s, x, q & m);
  endtask
  task automatic wirq(input logic x);
    int k;
    k = 0;
    while (irq !== x && k < 2000) begin @(posedge core_clk); k++; end
    chk("irq", {31'h0, x}, {31'h0, irq});
    if (k >= 2000) end_sim();
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("unmapped", 1, {31'h0, e});
    rdc("divl", A_DIVL, 32'hffff_ffff, 0);
    rdc("brk", A_BRK, 32'hffff_ffff, 0);
    wr(A_DIVH, 8'h12);
    rdc("divh", A_DIVH, 32'hffff_ffff, 32'h0000_0012);
    wr(A_DIVH, 8'h00);
    wr(A_DIVL, 8'h07);
    wr(A_BRK, 8'h37);
    rdc("brk_cfg", A_BRK, 32'hffff_ffff, 32'h0000_0037);
    RN.send(8'ha3);
    RN.send(8'h5c);
    repeat (16) @(posedge core_clk);
    rdc("rx0", A_DATA, 32'hffff_ffff, 32'h0000_00a3);
    rdc("rx1", A_DATA, 32'hffff_ffff, 32'h0000_005c);
    wr(A_IRQ, 8'h80);
    // Break lengths with and without sync; data queued during the first
    for (int i = 0; i < 4; i++) begin
      wr(A_BRK, {5'h10, r_sync[i], r_len[i]});
      fork
        RN.low_run(n);
        begin
          wr(A_CTRL, 8'h08);
          rdc("busy", A_CTRL, 8, 8);
          if (i == 0) wr(A_DATA, 8'h3c);
        end
      join
      chk("brk_len", r_low[i], n);
      if (r_sync[i]) begin RN.get_rest(b); chk("sync", 8'h55, b); end
      if (i == 0) begin RN.get_byte(b); chk("queued", 8'h3c, b); end
      wirq(1'b1);
      rdc("brk_flag", A_BRK, 8, 8);
      rdc("idle", A_CTRL, 8, 0);
      wr(A_BRK, 8'h80);
      wirq(1'b0);
    end
    // A receive at the 50% point, then transmit completion with the global enable off
    RN.send(8'h0f);
    repeat (16) @(posedge core_clk);
    rdc("rx50", A_DATA, 32'hffff_ffff, 32'h0000_000f);
    wr(A_IRQ, 8'h00);
    rdc("tx_pre", A_IRQ, 1, 0);
    wr(A_IRQ, 8'h01);
    wr(A_DATA, 8'h96);
    chk("irq_early", 0, {31'h0, irq});
    RN.get_byte(b);
    chk("tx", 8'h96, b);
    repeat (24) @(posedge core_clk);
    chk("irq_gie", 0, {31'h0, irq});
    rdc("tx_flag", A_IRQ, 1, 1);
    wr(A_IRQ, 8'h81);
    wirq(1'b1);
    wr(A_IRQ, 8'h80);
    wirq(1'b0);
    rdc("tx_clr", A_IRQ, 1, 0);
    end_sim();
  end
endmodule // eub_uart_tb
